// ===== logic/crl_pkg.sv
/*
 * Package for the readout lock block: section selects, mode codes, widths
 * and reset values shared by the design.
 * Assumes a single 40 MHz system clock and no other consumers.
 */
package crl_pkg;
   // ******************************
   // sizes
   // ******************************
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int GLOBAL_BITS = 8;
   localparam int PORT_BITS = 24;
   localparam int LOCK_BIT_POS = 1;

   // ******************************
   // section selects for the programmer port
   // ******************************
   typedef enum logic [1:0] {
      CRL_SEC_PROG = 2'h0,
      CRL_SEC_DECODER = 2'h1,
      CRL_SEC_GLOBAL = 2'h2,
      CRL_SEC_PORT = 2'h3
   } crl_sec_t;

   // ******************************
   // programmer mode requests
   // ******************************
   typedef enum logic [1:0] {
      CRL_MODE_RUN = 2'h0,
      CRL_MODE_INIT = 2'h1,
      CRL_MODE_DIRECT = 2'h2
   } crl_mode_t;

   // ******************************
   // reset values: erased cells read one, lock cell one means unlocked
   // ******************************
   localparam logic [GLOBAL_BITS-1:0] GLOBAL_ERASED = 8'hFF;
   localparam logic [PORT_BITS-1:0] PORT_ERASED = 24'hFFFFFF;
   localparam logic [15:0] LFSR_SEED = 16'hACE1;
   localparam logic [15:0] LFSR_TAPS = 16'hB400;
endpackage

// ===== logic/crl_readout_lock.sv
/*
 * Readout lock: configuration storage (global and port sections), the
 * programmer access path with lock gating, and the in-system access path.
 * Assumes program memory and decoder array lie outside; their read data
 * arrive on ports. All inputs are synchronous to sys_clk_i.
 */
// The implementer's own choices: the register addresses and the strobed register port.
// Overview of operation
// - locked device refuses programmer upload of program, decoder, global and port sections.
// - locked upload returns pseudo-random data, not stored contents.
// - in-system accesses behave identically whether locked or not.
// - any programmer read or verify on a locked device mismatches contents.
// - configuration writes only in programming phase; hidden in operational mode.
// - global section holds bus interface settings.
// - port section holds setup for ports A, B and C.
// - lock flag is one bit of global section, written like others.
// - chip-select high enters power-down; configuration bits keep their values.
// - locked device refuses initialization/override and direct modes.
// - only a full erase clears the lock flag; here rst_i also loads GLOBAL_ERASED and clears it.
// - lock cell zero means locked, one means unlocked.
`timescale 1ns/100ps
`default_nettype none
module crl_readout_lock
   import crl_pkg::*;
#(
   parameter int ADDR_WIDTH = crl_pkg::ADDR_W
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // programmer side
   input wire crl_pkg::crl_mode_t pgm_mode_i,
   input wire crl_pkg::crl_sec_t pgm_sec_i,
   input wire logic [ADDR_WIDTH-1:0] pgm_addr_i,
   input wire logic [crl_pkg::DATA_W-1:0] pgm_wdata_i,
   input wire logic pgm_wr_i,
   input wire logic pgm_rd_i,
   input wire logic pgm_erase_i,
   input wire logic [crl_pkg::DATA_W-1:0] prog_mem_rdata_i,
   input wire logic [crl_pkg::DATA_W-1:0] decoder_rdata_i,
   output logic [crl_pkg::DATA_W-1:0] pgm_rdata_o,
   output logic pgm_rvalid_o,
   output logic pgm_mode_ok_o,
   output logic pgm_mem_wr_o,
   // in-system side
   input wire logic chip_sel_n_i,
   input wire logic mcu_rd_i,
   input wire logic [ADDR_WIDTH-1:0] mcu_addr_i,
   output logic [crl_pkg::DATA_W-1:0] mcu_rdata_o,
   output logic mcu_rvalid_o,
   output logic power_down_o,
   output logic readout_lock_flag_o,
   output logic [crl_pkg::GLOBAL_BITS-1:0] global_cfg_o,
   output logic [crl_pkg::PORT_BITS-1:0] port_cfg_o
);
   import crl_pkg::*;

   // elaboration-time refusals: the port byte select needs two address bits,
   // and the readout mux assumes byte-wide sections
   if (ADDR_WIDTH < 2 || ADDR_WIDTH > 32) begin : g_addr_width_chk
      $error("ADDR_WIDTH out of range");
   end
   if (PORT_BITS != 3 * DATA_W) begin : g_port_bits_chk
      $error("port section must hold three data bytes");
   end
   if (LOCK_BIT_POS >= GLOBAL_BITS) begin : g_lock_pos_chk
      $error("lock bit lies outside the global section");
   end
   if (DATA_W != GLOBAL_BITS) begin : g_data_w_chk
      $error("global section must read back as one data byte");
   end

   // ******************************
   // storage
   // ******************************
   // flops stand in for the nonvolatile cells; reset loads erased values
   logic [GLOBAL_BITS-1:0] global_config_section;
   logic [PORT_BITS-1:0] port_config_section;
   logic [15:0] lfsr;
   logic locked;
   logic prog_phase;
   logic mode_ok;
   logic [1:0] port_idx;

   assign locked = ~global_config_section[LOCK_BIT_POS];
   // locked parts never get into init/direct modes
   assign prog_phase = (pgm_mode_i != CRL_MODE_RUN);
   assign mode_ok = prog_phase & ~locked;
   assign port_idx = pgm_addr_i[1:0];

   // ports A, B, C sit at indexes 0 to 2; index 3 has no cells behind it
   function automatic logic port_byte_ok(input logic [1:0] idx);
      return idx != 2'h3;
   endfunction

   // ******************************
   // configuration writes and erase
   // ******************************
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         global_config_section <= GLOBAL_ERASED;
      end else if (pgm_erase_i) begin
         global_config_section <= GLOBAL_ERASED;
      end else if (mode_ok && pgm_wr_i && pgm_sec_i == CRL_SEC_GLOBAL) begin
         // programming only clears cells; the lock cell cannot be set back to one
         global_config_section <= global_config_section & pgm_wdata_i;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         port_config_section <= PORT_ERASED;
      end else if (pgm_erase_i) begin
         port_config_section <= PORT_ERASED;
      end else if (mode_ok && pgm_wr_i && pgm_sec_i == CRL_SEC_PORT && port_byte_ok(port_idx)) begin
         // one byte per port A, B, C
         port_config_section[port_idx*8 +: 8] <= port_config_section[port_idx*8 +: 8] & pgm_wdata_i;
      end
   end

   // ******************************
   // noise source for refused reads
   // ******************************
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lfsr <= LFSR_SEED;
      end else begin
         lfsr <= lfsr[0] ? ((lfsr >> 1) ^ LFSR_TAPS) : (lfsr >> 1);
      end
   end

   // ******************************
   // programmer readout
   // ******************************
   function automatic logic [DATA_W-1:0] sec_data(input crl_sec_t sec, input logic [1:0] idx,
                                                 input logic [DATA_W-1:0] pm, input logic [DATA_W-1:0] dc,
                                                 input logic [GLOBAL_BITS-1:0] gc,
                                                 input logic [PORT_BITS-1:0] pc);
      logic [DATA_W-1:0] r;
      r = 8'h00;
      case (sec)
         CRL_SEC_PROG: r = pm;
         CRL_SEC_DECODER: r = dc;
         CRL_SEC_GLOBAL: r = gc;
         CRL_SEC_PORT: r = port_byte_ok(idx) ? pc[idx*8 +: 8] : 8'h00;
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pgm_rdata_o <= 8'h00;
         pgm_rvalid_o <= 1'b0;
      end else begin
         pgm_rvalid_o <= pgm_rd_i & prog_phase;
         if (pgm_rd_i && prog_phase) begin
            // lock sampled in the request cycle; locked reads get noise
            if (locked) begin
               pgm_rdata_o <= lfsr[DATA_W-1:0];
            end else begin
               pgm_rdata_o <= sec_data(pgm_sec_i, port_idx, prog_mem_rdata_i, decoder_rdata_i,
                                       global_config_section, port_config_section);
            end
         end
      end
   end

   assign pgm_mode_ok_o = mode_ok;
   assign pgm_mem_wr_o = mode_ok & pgm_wr_i & (pgm_sec_i == CRL_SEC_PROG || pgm_sec_i == CRL_SEC_DECODER);

   // ******************************
   // in-system path: unaffected by the lock
   // ******************************
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         mcu_rdata_o <= 8'h00;
         mcu_rvalid_o <= 1'b0;
      end else begin
         mcu_rvalid_o <= mcu_rd_i & ~chip_sel_n_i & ~prog_phase;
         if (mcu_rd_i && !chip_sel_n_i && !prog_phase) begin
            mcu_rdata_o <= prog_mem_rdata_i;
         end
      end
   end

   // power-down only gates activity; storage is never touched by it
   assign power_down_o = chip_sel_n_i;
   assign readout_lock_flag_o = locked;
   assign global_cfg_o = global_config_section;
   assign port_cfg_o = port_config_section;

   // ******************************
   // checks
   // ******************************
   sequence locked_read_s;
      locked && pgm_rd_i && prog_phase;
   endsequence

   // writes the cells take: unlocked programming phase, no erase beside them
   sequence global_write_s;
      mode_ok && pgm_wr_i && !pgm_erase_i && pgm_sec_i == CRL_SEC_GLOBAL;
   endsequence

   sequence lock_write_s;
      mode_ok && pgm_wr_i && !pgm_erase_i && pgm_sec_i == CRL_SEC_GLOBAL && !pgm_wdata_i[LOCK_BIT_POS];
   endsequence

   sequence port_a_write_s;
      mode_ok && pgm_wr_i && !pgm_erase_i && pgm_sec_i == CRL_SEC_PORT && port_idx == 2'h0;
   endsequence

   sequence spare_write_s;
      pgm_wr_i && !pgm_erase_i && pgm_sec_i == CRL_SEC_PORT && port_idx == 2'h3;
   endsequence

   sequence mcu_read_s;
      mcu_rd_i && !chip_sel_n_i && !prog_phase;
   endsequence

   // programmer readout
   locked_noise_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      locked_read_s |=> pgm_rvalid_o && pgm_rdata_o == $past(lfsr[DATA_W-1:0]))
      else $error("locked read did not return noise");
   open_read_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !locked && prog_phase && pgm_rd_i && pgm_sec_i == CRL_SEC_GLOBAL |=> pgm_rdata_o == $past(global_cfg_o))
      else $error("unlocked read wrong");
   rdata_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !(pgm_rd_i && prog_phase) |=> $stable(pgm_rdata_o))
      else $error("read data moved without a read");
   run_silent_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !prog_phase |=> !pgm_rvalid_o)
      else $error("read answered in run mode");

   // mode gating
   locked_refuse_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      locked |-> !pgm_mode_ok_o && !pgm_mem_wr_o)
      else $error("locked device accepted mode");
   open_mode_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      prog_phase && !locked |-> pgm_mode_ok_o)
      else $error("unlocked device refused mode");
   run_no_mode_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !prog_phase |-> !pgm_mode_ok_o && !pgm_mem_wr_o)
      else $error("programming allowed in run mode");
   open_mem_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      prog_phase && !locked && pgm_wr_i && pgm_sec_i == CRL_SEC_PROG |-> pgm_mem_wr_o)
      else $error("unlocked array write refused");

   // lock flag life cycle
   lock_sticky_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      locked && !pgm_erase_i |=> locked)
      else $error("lock cleared without erase");
   lock_polarity_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      lock_write_s |=> readout_lock_flag_o && !global_cfg_o[LOCK_BIT_POS])
      else $error("cleared lock cell did not lock");
   lock_origin_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !locked && !(mode_ok && pgm_wr_i && pgm_sec_i == CRL_SEC_GLOBAL && !pgm_wdata_i[LOCK_BIT_POS])
      |=> !readout_lock_flag_o)
      else $error("lock set without a lock write");
   erase_clears_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      pgm_erase_i |=> !locked && port_cfg_o == PORT_ERASED)
      else $error("erase left contents");
   erase_polarity_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      pgm_erase_i |=> global_cfg_o[LOCK_BIT_POS] && !readout_lock_flag_o)
      else $error("erased lock cell not unlocked");

   // configuration writes
   global_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      global_write_s |=> global_cfg_o == ($past(global_cfg_o) & $past(pgm_wdata_i)))
      else $error("global write wrong");
   port_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      port_a_write_s |=> port_cfg_o[DATA_W-1:0] == ($past(port_cfg_o[DATA_W-1:0]) & $past(pgm_wdata_i))
      && $stable(port_cfg_o[PORT_BITS-1:DATA_W]))
      else $error("port write wrong");
   spare_byte_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      spare_write_s |=> $stable(port_cfg_o))
      else $error("spare port index changed cells");
   locked_write_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      locked && pgm_wr_i && !pgm_erase_i |=> $stable(global_cfg_o) && $stable(port_cfg_o))
      else $error("locked device took a write");
   run_frozen_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !prog_phase && !pgm_erase_i |=> $stable(global_cfg_o) && $stable(port_cfg_o))
      else $error("config changed in run mode");

   // in-system path and power-down
   pd_retain_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      power_down_o && !prog_phase && !pgm_erase_i |=> $stable(global_cfg_o))
      else $error("power-down changed config");
   pd_port_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      power_down_o && !prog_phase && !pgm_erase_i |=> $stable(port_cfg_o))
      else $error("power-down changed port config");
   mcu_path_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      mcu_read_s |=> mcu_rvalid_o && mcu_rdata_o == $past(prog_mem_rdata_i))
      else $error("in-system read wrong");
   mcu_refused_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      chip_sel_n_i |=> !mcu_rvalid_o)
      else $error("deselected device answered");
   mcu_only_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !(mcu_rd_i && !chip_sel_n_i && !prog_phase) |=> !mcu_rvalid_o)
      else $error("in-system answer without request");
   mcu_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !(mcu_rd_i && !chip_sel_n_i && !prog_phase) |=> $stable(mcu_rdata_o))
      else $error("in-system data moved without a read");

   // noise source: a stuck register would hand out stored-looking data
   noise_moves_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      1'b1 |=> lfsr != $past(lfsr))
      else $error("noise source stuck");
   noise_live_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      lfsr != 16'h0000)
      else $error("noise source dead");
endmodule
`default_nettype wire

// ===== test/crl_far_side.sv
/* Far-side model: program memory and decoder array read data.
   Assumes the bench drives both address buses. */
`timescale 1ns/100ps
`default_nettype none
module crl_far_side (
   input wire logic [15:0] pgm_addr_i,
   input wire logic [15:0] mcu_addr_i,
   input wire logic mcu_rd_i,
   output logic [7:0] prog_mem_rdata_o,
   output logic [7:0] decoder_rdata_o
);
   logic [7:0] a;
   // address bits 7:0 keep locations distinct; addresses 256 apart alias
   assign a = mcu_rd_i ? mcu_addr_i[7:0] : pgm_addr_i[7:0];
   assign prog_mem_rdata_o = a ^ 8'h5A;
   assign decoder_rdata_o = ~a;
endmodule
`default_nettype wire

// ===== test/test_crl_readout_lock.sv
/* Bench for crl_readout_lock: drives both access paths, queues expected reads.
   Assumes crl_far_side supplies array data. */
`timescale 1ns/100ps
`default_nettype none
module test_crl_readout_lock;
   import crl_pkg::*;
   logic sys_clk_i = 1'b0;
   logic rst_i = 1'b1;
   crl_mode_t mode = CRL_MODE_RUN;
   crl_sec_t sec = CRL_SEC_PROG;
   logic [15:0] paddr = 16'h0000, maddr = 16'h0000;
   logic [7:0] wdata = 8'h00, rdata, mdata, pm, dc, gcfg, g;
   logic [7:0] pb [3];
   logic wr = 1'b0, rd = 1'b0, erase = 1'b0, csn = 1'b0, mrd = 1'b0;
   logic rvalid, mode_ok, mem_wr, mvalid, pdown, lock, wok;
   logic [23:0] pcfg;
   logic [8:0] e;
   logic [8:0] q [$];
   int bad_count = 0, checks = 0, cycles = 0;
   crl_readout_lock dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .pgm_mode_i(mode), .pgm_sec_i(sec),
      .pgm_addr_i(paddr), .pgm_wdata_i(wdata), .pgm_wr_i(wr), .pgm_rd_i(rd), .pgm_erase_i(erase),
      .prog_mem_rdata_i(pm), .decoder_rdata_i(dc), .pgm_rdata_o(rdata), .pgm_rvalid_o(rvalid),
      .pgm_mode_ok_o(mode_ok), .pgm_mem_wr_o(mem_wr), .chip_sel_n_i(csn), .mcu_rd_i(mrd),
      .mcu_addr_i(maddr), .mcu_rdata_o(mdata), .mcu_rvalid_o(mvalid), .power_down_o(pdown),
      .readout_lock_flag_o(lock), .global_cfg_o(gcfg), .port_cfg_o(pcfg));
   crl_far_side far (.pgm_addr_i(paddr), .mcu_addr_i(maddr), .mcu_rd_i(mrd),
      .prog_mem_rdata_o(pm), .decoder_rdata_o(dc));
   initial forever #12.5 sys_clk_i = ~sys_clk_i;
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic pgm(input crl_sec_t s, input logic [15:0] a, input logic w, input logic [7:0] d);
      @(posedge sys_clk_i);
      sec <= s;
      paddr <= a;
      wr <= w;
      rd <= ~w;
      wdata <= d;
      @(negedge sys_clk_i);
      wok = mem_wr;
      @(posedge sys_clk_i);
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   // differ set: answer must not reproduce the stored value
   task automatic rdx(input crl_sec_t s, input logic [15:0] a, input logic [7:0] x, input logic dif);
      q.push_back({dif, x});
      pgm(s, a, 1'b0, 8'h00);
   endtask
   task automatic mcu(input logic [15:0] a);
      @(posedge sys_clk_i);
      maddr <= a;
      mrd <= 1'b1;
      @(posedge sys_clk_i);
      mrd <= 1'b0;
   endtask
   task automatic hold_check;
      @(negedge sys_clk_i);
      check("global_cfg", gcfg, g);
      for (int i = 0; i < 3; i++) check("port_cfg", pcfg[8*i +: 8], pb[i]);
   endtask
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         results();
      end else if (rvalid === 1'b1 || mvalid === 1'b1) begin
         if (q.size() == 0) check("unexpected_answer", 8'h01, 8'h00);
         else begin
            e = q.pop_front();
            if (e[8]) check("locked_noise", {7'h0, (rvalid ? rdata : mdata) === e[7:0]}, 8'h00);
            else check("read_data", rvalid ? rdata : mdata, e[7:0]);
         end
      end
   end
   initial begin
      void'($urandom(55));
      g = GLOBAL_ERASED;
      for (int i = 0; i < 3; i++) pb[i] = 8'hFF;
      repeat (16) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      // ************
      // operational mode hides configuration
      // ************
      pgm(CRL_SEC_GLOBAL, 16'h0000, 1'b1, 8'h00);
      pgm(CRL_SEC_GLOBAL, 16'h0000, 1'b0, 8'h00);
      pgm(CRL_SEC_PROG, 16'h0033, 1'b1, 8'h00);
      check("mem_wr", {7'h0, wok}, 8'h00);
      check("lock_flag", {7'h0, lock}, 8'h00);
      hold_check();
      $display("test run_mode done");
      @(posedge sys_clk_i);
      mode <= CRL_MODE_INIT;
      for (int i = 0; i < 3; i++) begin
         pb[i] = 8'($urandom);
         pgm(CRL_SEC_PORT, 16'(i), 1'b1, pb[i]);
         rdx(CRL_SEC_PORT, 16'(i), pb[i], 1'b0);
      end
      pgm(CRL_SEC_PORT, 16'h0003, 1'b1, 8'h00);
      rdx(CRL_SEC_PORT, 16'h0003, 8'h00, 1'b0);
      g = 8'($urandom) | 8'h02;
      pgm(CRL_SEC_GLOBAL, 16'h0000, 1'b1, g);
      rdx(CRL_SEC_GLOBAL, 16'h0000, g, 1'b0);
      rdx(CRL_SEC_PROG, 16'h0033, 8'h69, 1'b0);
      mode <= CRL_MODE_DIRECT;
      rdx(CRL_SEC_DECODER, 16'h0012, 8'hED, 1'b0);
      pgm(CRL_SEC_PROG, 16'h0033, 1'b1, 8'h00);
      check("mem_wr", {7'h0, wok}, 8'h01);
      hold_check();
      check("mode_ok", {7'h0, mode_ok}, 8'h01);
      $display("test program done");
      g = g & 8'hFD;
      pgm(CRL_SEC_GLOBAL, 16'h0000, 1'b1, 8'hFD);
      pgm(CRL_SEC_PORT, 16'h0001, 1'b1, 8'h00);
      hold_check();
      check("lock_flag", {7'h0, lock}, 8'h01);
      check("mode_ok", {7'h0, mode_ok}, 8'h00);
      rdx(CRL_SEC_PROG, 16'h0033, 8'h69, 1'b1);
      rdx(CRL_SEC_DECODER, 16'h0012, 8'hED, 1'b1);
      rdx(CRL_SEC_GLOBAL, 16'h0000, g, 1'b1);
      rdx(CRL_SEC_PORT, 16'h0002, pb[2], 1'b1);
      pgm(CRL_SEC_PROG, 16'h0033, 1'b1, 8'h00);
      check("mem_wr", {7'h0, wok}, 8'h00);
      $display("test locked done");
      mode <= CRL_MODE_RUN;
      q.push_back({1'b0, 8'h1E});
      mcu(16'h0044);
      csn <= 1'b1;
      mcu(16'h0045);
      @(negedge sys_clk_i);
      check("power_down", {7'h0, pdown}, 8'h01);
      @(posedge sys_clk_i);
      csn <= 1'b0;
      hold_check();
      $display("test in_system done");
      @(posedge sys_clk_i);
      erase <= 1'b1;
      @(posedge sys_clk_i);
      erase <= 1'b0;
      g = GLOBAL_ERASED;
      for (int i = 0; i < 3; i++) pb[i] = 8'hFF;
      hold_check();
      check("lock_flag", {7'h0, lock}, 8'h00);
      $display("test erase done");
      repeat (3) @(posedge sys_clk_i);
      results();
   end
endmodule
`default_nettype wire
